/* File: rtl/encoder_param_cmd_decoder.sv */
// Parameter channel command decoder with status reporting
`timescale 1ns/100ps

// Operation
// - Marked commands carry guard byte against overwrite
// - Guard byte expected is 55h after reset
// - 56h returns serial number and version
// - 4Ch reports status of selected field
// - 4Eh reports remaining user memory
// - No fault gives status 00h
// - Checksum mismatch flags 0Ah
// - Wrong data byte count flags 0Ch
// - Disallowed argument rejected, flags 0Dh
// - Write to protected field refused, 0Eh
// - Resizing fixed field refused, flags 10h
// - Word address beyond field flags 11h
// - Missing data field flags 12h
// - Overspeed flags 1Fh
// - Supervision reset flags 07h
// - Analog monitoring violation flags 1Ch
// - Internal two-wire bus failure flags 05h
// - Corrupt partition table flags 03h
module encoder_param_cmd_decoder
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic rxFrameEnd,
  input wire logic rxSumOk,
  input wire logic overspeedPin,
  input wire logic wdogResetPin,
  input wire logic analogFaultPin,
  input wire logic busFaultPin,
  input wire logic tableBadPin,
  output logic txByteValid,
  output logic [7:0] txByte,
  output logic txLast,
  output logic [7:0] status,
  output logic fieldWrite,
  output logic [param_cmd_pkg::FIELD_BITS-1:0] fieldSel,
  output logic [7:0] fieldAddr,
  output logic [7:0] fieldData
);
  import param_cmd_pkg::*;

  // ----------------------------------------
  // Frame collection
  // ----------------------------------------
  cmd_frame_if frame ();

  frame_collect u_collect (
    .clk(clk),
    .srst(srst),
    .byteValid(rxByteValid),
    .byteData(rxByte),
    .frameEnd(rxFrameEnd),
    .sumOk(rxSumOk),
    .frame(frame)
  );

  // ----------------------------------------
  // Fault pin synchronisers
  // ----------------------------------------
  logic [4:0] faultMeta_ff;
  logic [4:0] faultSync_ff;
  logic [4:0] faultPrev_ff;
  wire logic [4:0] faultRaw = {tableBadPin, busFaultPin, analogFaultPin,
    wdogResetPin, overspeedPin};
  wire logic [4:0] faultRise = faultSync_ff & ~faultPrev_ff;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      faultMeta_ff <= 5'h00;
      faultSync_ff <= 5'h00;
      faultPrev_ff <= 5'h00;
    end
    else
    begin
      faultMeta_ff <= faultRaw;
      faultSync_ff <= faultMeta_ff;
      faultPrev_ff <= faultSync_ff;
    end
  end

  // ----------------------------------------
  // Data field table
  // ----------------------------------------
  logic fieldExists_ff [0:NUM_FIELDS-1];
  logic fieldProt_ff [0:NUM_FIELDS-1];
  logic fieldFixed_ff [0:NUM_FIELDS-1];
  logic [7:0] fieldSize_ff [0:NUM_FIELDS-1];
  logic [15:0] freeMem_ff;
  logic [7:0] guard_ff;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic [7:0] cmd = frame.cmd;
  wire logic [7:0] a0 = frame.arg[0];
  wire logic [7:0] a1 = frame.arg[1];
  wire logic [7:0] a2 = frame.arg[2];
  wire logic [7:0] a3 = frame.arg[3];

  wire logic known = cmd inside {CMD_READ_POS, CMD_SET_POS,
    CMD_READ_ANALOG, CMD_READ_CNT, CMD_INC_CNT, CMD_DEL_CNT,
    CMD_READ_DATA, CMD_STORE_DATA, CMD_FIELD_STAT, CMD_CREATE_FIELD,
    CMD_FREE_MEM, CMD_CHG_CODE, CMD_READ_STATUS, CMD_TYPE_LABEL,
    CMD_RESET, CMD_SET_ADDR, CMD_SERIAL_VER, CMD_CFG_IF};

  wire logic guarded = cmd inside {CMD_SET_POS, CMD_DEL_CNT,
    CMD_CREATE_FIELD, CMD_CHG_CODE, CMD_CFG_IF};

  logic [3:0] expLen;
  always_comb
  begin
    case (cmd)
      CMD_SET_POS: expLen = LEN_FOUR;
      CMD_READ_ANALOG: expLen = LEN_ONE;
      CMD_DEL_CNT: expLen = LEN_ONE;
      CMD_READ_DATA: expLen = LEN_TWO;
      CMD_STORE_DATA: expLen = LEN_THREE;
      CMD_FIELD_STAT: expLen = LEN_ONE;
      CMD_CREATE_FIELD: expLen = LEN_FOUR;
      CMD_CHG_CODE: expLen = LEN_THREE;
      CMD_SET_ADDR: expLen = LEN_ONE;
      CMD_CFG_IF: expLen = LEN_TWO;
      default: expLen = LEN_NONE;
    endcase
  end

  // Guard byte sits first for guarded commands
  wire logic guardOk = !guarded || (a0 == guard_ff);
  wire logic [7:0] fieldArg = (cmd == CMD_CREATE_FIELD) ? a1 : a0;
  wire logic [FIELD_BITS-1:0] fIdx = fieldArg[FIELD_BITS-1:0];
  wire logic fInRange = fieldArg < 8'(NUM_FIELDS);
  wire logic fExists = fInRange && fieldExists_ff[fIdx];
  wire logic isWrite = cmd == CMD_STORE_DATA;
  wire logic isAccess = cmd == CMD_READ_DATA || isWrite;
  wire logic needField = isAccess || cmd == CMD_FIELD_STAT;

  // Status picked by priority: protocol, argument, then data checks
  logic [7:0] verdict;
  always_comb
  begin
    if (!frame.sumOk)
      verdict = ST_CHECKSUM;
    else if (!known)
      verdict = ST_UNKNOWN_CMD;
    else if (frame.count != expLen)
      verdict = ST_DATA_COUNT;
    else if (!guardOk)
      verdict = ST_BAD_CODE;
    else if ((needField || cmd == CMD_CREATE_FIELD) && !fInRange)
      verdict = ST_BAD_ARG;
    else if (needField && !fExists)
      verdict = ST_NO_FIELD;
    else if (isWrite && fieldProt_ff[fIdx])
      verdict = ST_WRITE_PROT;
    else if (cmd == CMD_CREATE_FIELD && fExists && fieldFixed_ff[fIdx])
      verdict = ST_FIXED_SIZE;
    else if (cmd == CMD_CREATE_FIELD && a2 > FIELD_WORDS_MAX)
      verdict = ST_BAD_ARG;
    else if (isAccess && a1 >= fieldSize_ff[fIdx])
      verdict = ST_ADDR_RANGE;
    else
      verdict = ST_OK;
  end

  wire logic accept = frame.valid && verdict == ST_OK;

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  // Pin faults win over frame verdicts: they reflect device health
  always_comb
  begin
    nxt_status = status_ff;
    // A clean status read must not hide the code that it reports
    if (frame.valid && !(cmd == CMD_READ_STATUS && verdict == ST_OK))
      nxt_status = verdict;
    if (faultRise[0])
      nxt_status = ST_OVERSPEED;
    if (faultRise[1])
      nxt_status = ST_WDOG_RESET;
    if (faultRise[2])
      nxt_status = ST_ANALOG_MON;
    if (faultRise[3])
      nxt_status = ST_I2C_DEAD;
    if (faultRise[4])
      nxt_status = ST_TABLE_BAD;
  end

  // ----------------------------------------
  // State updates: status every cycle, guard and fields on accepted commands
  // ----------------------------------------
  wire logic doCreate = accept && cmd == CMD_CREATE_FIELD;
  wire logic [15:0] newWords = {8'h00, a2};
  wire logic memShort = newWords > freeMem_ff;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      status_ff <= ST_OK;
      guard_ff <= GUARD_RESET;
      freeMem_ff <= USER_MEM_BYTES;
    end
    else
    begin
      status_ff <= nxt_status;
      if (accept && cmd == CMD_CHG_CODE)
        guard_ff <= a1;
      if (doCreate && !fExists && !memShort)
        freeMem_ff <= freeMem_ff - newWords;
    end
  end

  genvar g;
  for (g = 0; g < NUM_FIELDS; g++)
  begin : g_field
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        fieldExists_ff[g] <= 1'b0;
        fieldProt_ff[g] <= 1'b0;
        fieldFixed_ff[g] <= 1'b0;
        fieldSize_ff[g] <= 8'h00;
      end
      else if (doCreate && fIdx == FIELD_BITS'(g) && !memShort)
      begin
        fieldExists_ff[g] <= 1'b1;
        fieldSize_ff[g] <= a2;
        fieldProt_ff[g] <= a3[0];
        fieldFixed_ff[g] <= a3[1];
      end
    end
  end

  // ----------------------------------------
  // Reply shaping
  // ----------------------------------------
  logic [7:0] reply [0:MAX_REPLY-1];
  logic [2:0] replyLen;
  always_comb
  begin
    for (int k = 0; k < MAX_REPLY; k++)
      reply[k] = 8'h00;
    replyLen = 3'd0;
    if (accept)
    begin
      case (cmd)
        CMD_SERIAL_VER:
        begin
          reply[0] = SERIAL_NO[31:24];
          reply[1] = SERIAL_NO[23:16];
          reply[2] = SERIAL_NO[15:8];
          reply[3] = SERIAL_NO[7:0];
          reply[4] = FW_VERSION;
          replyLen = 3'd5;
        end
        CMD_FIELD_STAT:
        begin
          reply[0][FST_EXISTS] = fieldExists_ff[fIdx];
          reply[0][FST_PROT] = fieldProt_ff[fIdx];
          reply[0][FST_FIXED] = fieldFixed_ff[fIdx];
          reply[1] = fieldSize_ff[fIdx];
          replyLen = 3'd2;
        end
        CMD_FREE_MEM:
        begin
          reply[0] = freeMem_ff[15:8];
          reply[1] = freeMem_ff[7:0];
          replyLen = 3'd2;
        end
        CMD_TYPE_LABEL:
        begin
          reply[0] = TYPE_CODE;
          replyLen = 3'd1;
        end
        CMD_READ_STATUS:
        begin
          reply[0] = status_ff;
          replyLen = 3'd1;
        end
        default:
        begin
          reply[0] = ST_OK;
          replyLen = 3'd1;
        end
      endcase
    end
    else if (frame.valid)
    begin
      reply[0] = verdict;
      replyLen = 3'd1;
    end
  end

  // ----------------------------------------
  // Transmit sequencer
  // ----------------------------------------
  logic [7:0] txBuf_ff [0:MAX_REPLY-1];
  logic [2:0] txLeft_ff;
  logic [2:0] txPos_ff;
  wire logic loadTx = replyLen != 3'd0 && txLeft_ff == 3'd0;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      txLeft_ff <= 3'd0;
      txPos_ff <= 3'd0;
      txByteValid <= 1'b0;
      txByte <= 8'h00;
      txLast <= 1'b0;
    end
    else if (loadTx)
    begin
      txBuf_ff <= reply;
      txLeft_ff <= replyLen;
      txPos_ff <= 3'd0;
      txByteValid <= 1'b0;
      txLast <= 1'b0;
    end
    else if (txLeft_ff != 3'd0)
    begin
      txByteValid <= 1'b1;
      txByte <= txBuf_ff[txPos_ff];
      txLast <= txLeft_ff == 3'd1;
      txPos_ff <= txPos_ff + 3'd1;
      txLeft_ff <= txLeft_ff - 3'd1;
    end
    else
    begin
      txByteValid <= 1'b0;
      txLast <= 1'b0;
    end
  end

  // ----------------------------------------
  // Field write strobe toward memory
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fieldWrite <= 1'b0;
      fieldSel <= '0;
      fieldAddr <= 8'h00;
      fieldData <= 8'h00;
    end
    else
    begin
      fieldWrite <= accept && isWrite;
      fieldSel <= fIdx;
      fieldAddr <= a1;
      fieldData <= a2;
    end
  end

  assign status = status_ff;

endmodule

/* File: include/param_cmd_pkg.sv */
// Package with command codes, status codes and device constants for the decoder
package param_cmd_pkg;

  // ----------------------------------------
  // Command bytes
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_POS = 8'h42;
  localparam logic [7:0] CMD_SET_POS = 8'h43;
  localparam logic [7:0] CMD_READ_ANALOG = 8'h44;
  localparam logic [7:0] CMD_READ_CNT = 8'h46;
  localparam logic [7:0] CMD_INC_CNT = 8'h47;
  localparam logic [7:0] CMD_DEL_CNT = 8'h49;
  localparam logic [7:0] CMD_READ_DATA = 8'h4A;
  localparam logic [7:0] CMD_STORE_DATA = 8'h4B;
  localparam logic [7:0] CMD_FIELD_STAT = 8'h4C;
  localparam logic [7:0] CMD_CREATE_FIELD = 8'h4D;
  localparam logic [7:0] CMD_FREE_MEM = 8'h4E;
  localparam logic [7:0] CMD_CHG_CODE = 8'h4F;
  localparam logic [7:0] CMD_READ_STATUS = 8'h50;
  localparam logic [7:0] CMD_TYPE_LABEL = 8'h52;
  localparam logic [7:0] CMD_RESET = 8'h53;
  localparam logic [7:0] CMD_SET_ADDR = 8'h55;
  localparam logic [7:0] CMD_SERIAL_VER = 8'h56;
  localparam logic [7:0] CMD_CFG_IF = 8'h57;

  // ----------------------------------------
  // Status codes
  // ----------------------------------------
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_TABLE_BAD = 8'h03;
  localparam logic [7:0] ST_I2C_DEAD = 8'h05;
  localparam logic [7:0] ST_WDOG_RESET = 8'h07;
  localparam logic [7:0] ST_CHECKSUM = 8'h0A;
  localparam logic [7:0] ST_UNKNOWN_CMD = 8'h0B;
  localparam logic [7:0] ST_DATA_COUNT = 8'h0C;
  localparam logic [7:0] ST_BAD_ARG = 8'h0D;
  localparam logic [7:0] ST_WRITE_PROT = 8'h0E;
  localparam logic [7:0] ST_BAD_CODE = 8'h0F;
  localparam logic [7:0] ST_FIXED_SIZE = 8'h10;
  localparam logic [7:0] ST_ADDR_RANGE = 8'h11;
  localparam logic [7:0] ST_NO_FIELD = 8'h12;
  localparam logic [7:0] ST_ANALOG_MON = 8'h1C;
  localparam logic [7:0] ST_OVERSPEED = 8'h1F;

  // ----------------------------------------
  // Reset values and device constants
  // ----------------------------------------
  localparam logic [7:0] GUARD_RESET = 8'h55;
  localparam logic [7:0] TYPE_CODE = 8'hA5;     // Arbitrary type code
  localparam logic [7:0] FW_VERSION = 8'h01;    // Arbitrary version
  localparam logic [31:0] SERIAL_NO = 32'h0000_0001; // Arbitrary serial
  localparam logic [15:0] USER_MEM_BYTES = 16'h0700;
  localparam int NUM_FIELDS = 8;
  localparam logic [7:0] FIELD_WORDS_MAX = 8'h20;
  localparam int FIELD_BITS = 3;
  localparam int MAX_REPLY = 5;

  // ----------------------------------------
  // Data field status byte layout
  // ----------------------------------------
  localparam int FST_EXISTS = 7;
  localparam int FST_PROT = 6;
  localparam int FST_FIXED = 5;

  // Expected data-byte counts per command
  localparam logic [3:0] LEN_NONE = 4'h0;
  localparam logic [3:0] LEN_ONE = 4'h1;
  localparam logic [3:0] LEN_TWO = 4'h2;
  localparam logic [3:0] LEN_THREE = 4'h3;
  localparam logic [3:0] LEN_FOUR = 4'h4;

endpackage

/* File: include/cmd_frame_if.sv */
// Interface carrying one decoded frame from the collector to the decoder
`timescale 1ns/100ps
interface cmd_frame_if;
  logic valid;
  logic [7:0] cmd;
  logic [3:0] count;
  logic [7:0] arg [0:3];
  logic sumOk;
  modport src (output valid, output cmd, output count, output arg,
    output sumOk);
  modport dst (input valid, input cmd, input count, input arg,
    input sumOk);
endinterface

/* File: rtl/frame_collect.sv */
// Collects received bytes of one message into a frame
`timescale 1ns/100ps
module frame_collect
(
  input wire logic clk,
  input wire logic srst,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic frameEnd,
  input wire logic sumOk,
  cmd_frame_if.src frame
);
  import param_cmd_pkg::*;

  logic [3:0] cnt_ff;
  logic haveCmd_ff;
  logic [7:0] cmd_ff;
  logic [7:0] arg_ff [0:3];
  logic valid_ff;
  logic sum_ff;
  logic [3:0] countOut_ff;

  wire logic storeArg = byteValid && haveCmd_ff && (cnt_ff < 4'h4);
  wire logic [1:0] argIdx = cnt_ff[1:0];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_ff <= 4'h0;
      haveCmd_ff <= 1'b0;
      cmd_ff <= 8'h00;
      valid_ff <= 1'b0;
      sum_ff <= 1'b0;
      countOut_ff <= 4'h0;
    end
    else
    begin
      valid_ff <= frameEnd && haveCmd_ff;
      if (frameEnd)
      begin
        sum_ff <= sumOk;
        countOut_ff <= cnt_ff;
        haveCmd_ff <= 1'b0;
        cnt_ff <= 4'h0;
      end
      else if (byteValid && !haveCmd_ff)
      begin
        cmd_ff <= byteData;
        haveCmd_ff <= 1'b1;
      end
      else if (byteValid && cnt_ff != 4'hF)
        cnt_ff <= cnt_ff + 4'h1;
    end
  end

  // Argument bytes beyond four are counted but not kept
  genvar i;
  for (i = 0; i < 4; i++)
  begin : g_arg
    always_ff @(posedge clk)
    begin
      if (srst)
        arg_ff[i] <= 8'h00;
      else if (storeArg && argIdx == 2'(i))
        arg_ff[i] <= byteData;
    end
    assign frame.arg[i] = arg_ff[i];
  end

  assign frame.valid = valid_ff;
  assign frame.cmd = cmd_ff;
  assign frame.count = countOut_ff;
  assign frame.sumOk = sum_ff;

endmodule

/* File: verification/decoder_monitor.sv */
// Port-level assertions of the parameter channel command decoder
`timescale 1ns/100ps
module decoder_monitor
(
  input wire logic clk,
  input wire logic srst,
  input wire logic rxByteValid,
  input wire logic [7:0] rxByte,
  input wire logic rxFrameEnd,
  input wire logic rxSumOk,
  input wire logic overspeedPin,
  input wire logic wdogResetPin,
  input wire logic analogFaultPin,
  input wire logic busFaultPin,
  input wire logic tableBadPin,
  input wire logic txByteValid,
  input wire logic [7:0] txByte,
  input wire logic txLast,
  input wire logic [7:0] status,
  input wire logic fieldWrite,
  input wire logic [param_cmd_pkg::FIELD_BITS-1:0] fieldSel,
  input wire logic [7:0] fieldAddr,
  input wire logic [7:0] fieldData
);
  import param_cmd_pkg::*;
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  // Reply window allows for the frame register, the transmit buffer load and the output register
  sequence sReplyStart;
    ##[3:5] txByteValid;
  endsequence

  sequence sFlagged(logic [7:0] code);
    ##[2:6] (status == code);
  endsequence

  // Pin edges pass a two-stage synchroniser before they are flagged
  property pFault(logic pin, logic [7:0] code);
    @(posedge clk) disable iff (srst) $rose(pin) |-> sFlagged(code);
  endproperty

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_REPLY_START: assert property (@(posedge clk) disable iff (srst)
    rxFrameEnd |-> sReplyStart) else $error("reply did not start");
  AST_CHECKSUM: assert property (@(posedge clk) disable iff (srst)
    rxFrameEnd && !rxSumOk |-> ##[2:3] (status == 8'h0A))
    else $error("checksum fault not flagged");
  AST_BURST: assert property (@(posedge clk) disable iff (srst)
    txByteValid && !txLast |=> txByteValid)
    else $error("reply burst broken");
  AST_RESET_QUIET: assert property (@(posedge clk)
    srst |=> (status == 8'h00) && !txByteValid && !fieldWrite)
    else $error("outputs not cleared by reset");
  AST_OVERSPEED: assert property (pFault(overspeedPin, 8'h1F))
    else $error("overspeed not flagged");
  AST_WDOG: assert property (pFault(wdogResetPin, 8'h07))
    else $error("supervision reset not flagged");
  AST_ANALOG: assert property (pFault(analogFaultPin, 8'h1C))
    else $error("analog monitor fault not flagged");
  AST_BUS: assert property (pFault(busFaultPin, 8'h05))
    else $error("peripheral bus fault not flagged");
  AST_TABLE: assert property (pFault(tableBadPin, 8'h03))
    else $error("partition table fault not flagged");
endmodule

/* File: verification/drive_ctrl_model.sv */
// Behavioural drive controller that sends command frames
`timescale 1ns/100ps
module drive_ctrl_model
(
  input wire logic clk,
  output logic rxByteValid,
  output logic [7:0] rxByte,
  output logic rxFrameEnd,
  output logic rxSumOk
);
  initial
  begin
    rxByteValid = 1'b0;
    rxByte = 8'hA5;
    rxFrameEnd = 1'b0;
    rxSumOk = 1'b0;
  end

  // ----------------------------------------
  // Frame sender
  // ----------------------------------------
  // command byte first, then argument bytes from a[31:24] down
  // Idle data is inverted in the frame-end cycle only, then restored to the last byte sent
  task automatic sendFrame(input logic [7:0] cmd, input int n,
    input logic [31:0] a, input logic ok);
    int k;
    @(posedge clk);
    rxByteValid <= 1'b1;
    rxByte <= cmd;
    for (k = 0; k < n; k++)
    begin
      @(posedge clk);
      rxByte <= a[31-8*k -: 8];
    end
    @(posedge clk);
    rxByteValid <= 1'b0;
    rxByte <= ~rxByte;
    rxFrameEnd <= 1'b1;
    rxSumOk <= ok;
    @(posedge clk);
    rxFrameEnd <= 1'b0;
    rxSumOk <= ~ok;
    rxByte <= ~rxByte;
  endtask
endmodule

/* File: verification/tb_encoder_param_cmd_decoder.sv */
// Self-checking testbench of the parameter channel command decoder
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    nTests++; \
    if ((got) !== (exp)) \
    begin \
      numErrors++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end
module tb_encoder_param_cmd_decoder;
  import param_cmd_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] pins = 5'h00;
  logic [39:0] codes = 40'h03_05_1C_07_1F;
  wire logic rxByteValid;
  wire logic [7:0] rxByte;
  wire logic rxFrameEnd;
  wire logic rxSumOk;
  logic txByteValid;
  logic [7:0] txByte;
  logic txLast;
  logic [7:0] status;
  logic fieldWrite;
  logic [FIELD_BITS-1:0] fieldSel;
  logic [7:0] fieldAddr;
  logic [7:0] fieldData;
  logic [FIELD_BITS-1:0] wrSel;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  int numErrors = 0;
  int nTests = 0;
  int wrCnt = 0;
  logic [31:0] rnd = 32'h0001194A;
  logic [7:0] rep [$];

  always #2 clk = ~clk;

  drive_ctrl_model u_ctrl (.clk(clk), .rxByteValid(rxByteValid),
    .rxByte(rxByte), .rxFrameEnd(rxFrameEnd), .rxSumOk(rxSumOk));

  encoder_param_cmd_decoder DUT (.clk(clk), .srst(srst),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxFrameEnd(rxFrameEnd),
    .rxSumOk(rxSumOk), .overspeedPin(pins[0]), .wdogResetPin(pins[1]),
    .analogFaultPin(pins[2]), .busFaultPin(pins[3]), .tableBadPin(pins[4]),
    .txByteValid(txByteValid), .txByte(txByte), .txLast(txLast),
    .status(status), .fieldWrite(fieldWrite), .fieldSel(fieldSel),
    .fieldAddr(fieldAddr), .fieldData(fieldData));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (fieldWrite === 1'b1)
    begin
      wrCnt++;
      wrSel = fieldSel;
      wrAddr = fieldAddr;
      wrData = fieldData;
    end
  end

  function automatic logic [31:0] nxtRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected field status reply: flag byte, then size
  function automatic logic [15:0] fieldStat(input logic ex, input logic pr,
    input logic fx, input logic [7:0] sz);
    logic [7:0] s;
    s = 8'h00;
    s[FST_EXISTS] = ex;
    s[FST_PROT] = pr;
    s[FST_FIXED] = fx;
    return {s, sz};
  endfunction

  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One frame, whole reply collected; error replies carry the verdict
  task automatic run(input logic [7:0] cmd, input int n,
    input logic [31:0] a, input logic ok, input logic [7:0] expSt);
    int i;
    rep.delete();
    u_ctrl.sendFrame(cmd, n, a, ok);
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      #1;
      if (txByteValid === 1'b1)
        rep.push_back(txByte);
      if (txLast === 1'b1)
        break;
    end
    if (i == 40)
    begin
      numErrors++;
      endOfTest();
    end
    else
    begin
      `CHK(status, expSt)
      if (expSt != 8'h00)
      begin
        `CHK(rep.size(), 1)
        `CHK(rep[0], expSt)
      end
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int i;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    run(CMD_FREE_MEM, 0, 32'h0, 1'b1, 8'h00);
    `CHK({rep[0], rep[1]}, USER_MEM_BYTES)
    run(CMD_SERIAL_VER, 0, 32'h0, 1'b1, 8'h00);
    `CHK(rep.size(), 5)
    `CHK({rep[0], rep[1], rep[2], rep[3]}, SERIAL_NO)
    `CHK(rep[4], FW_VERSION)
    run(CMD_TYPE_LABEL, 0, 32'h0, 1'b1, 8'h00);
    `CHK(rep[0], TYPE_CODE)
    run(CMD_FREE_MEM, 0, 32'h0, 1'b0, 8'h0A);
    for (i = 0; i < 4; i++)
    begin
      rnd = nxtRand(rnd);
      run(8'h80 | rnd[7:0], 0, 32'h0, 1'b1, 8'h0B);
    end
    run(CMD_FREE_MEM, 0, 32'h0, 1'b1, 8'h00);
    `CHK({rep[0], rep[1]}, USER_MEM_BYTES)
    run(CMD_FREE_MEM, 1, 32'h1200_0000, 1'b1, 8'h0C);
    run(CMD_FIELD_STAT, 1, 32'h0800_0000, 1'b1, 8'h0D);
    run(CMD_READ_DATA, 2, 32'h0300_0000, 1'b1, 8'h12);
    run(CMD_CREATE_FIELD, 4, 32'h5401_0401, 1'b1, 8'h0F);
    run(CMD_CREATE_FIELD, 4, 32'h5501_0401, 1'b1, 8'h00);
    run(CMD_CREATE_FIELD, 4, 32'h5502_0202, 1'b1, 8'h00);
    run(CMD_CREATE_FIELD, 4, 32'h5503_0200, 1'b1, 8'h00);
    run(CMD_FIELD_STAT, 1, 32'h0100_0000, 1'b1, 8'h00);
    `CHK({rep[0], rep[1]}, fieldStat(1'b1, 1'b1, 1'b0, 8'h04))
    run(CMD_FREE_MEM, 0, 32'h0, 1'b1, 8'h00);
    `CHK({rep[0], rep[1]}, USER_MEM_BYTES - 16'h0008)
    i = wrCnt;
    run(CMD_STORE_DATA, 3, 32'h0100_0000, 1'b1, 8'h0E);
    `CHK(wrCnt, i)
    run(CMD_CREATE_FIELD, 4, 32'h5502_0302, 1'b1, 8'h10);
    rnd = nxtRand(rnd);
    run(CMD_STORE_DATA, 3, {16'h0301, rnd[7:0], 8'h00}, 1'b1, 8'h00);
    `CHK(wrCnt, i + 1)
    `CHK({wrSel, wrAddr, wrData}, {3'h3, 8'h01, rnd[7:0]})
    run(CMD_STORE_DATA, 3, {16'h0302, rnd[7:0], 8'h00}, 1'b1, 8'h11);
    // Status read leaves the last verdict in place
    run(CMD_READ_STATUS, 0, 32'h0, 1'b1, 8'h11);
    // New guard code: the delivery value is refused until reset
    run(CMD_CHG_CODE, 3, 32'h5566_0000, 1'b1, 8'h00);
    run(CMD_CREATE_FIELD, 4, 32'h5504_0100, 1'b1, 8'h0F);
    run(CMD_CREATE_FIELD, 4, 32'h6604_2100, 1'b1, 8'h0D);
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk);
      pins[i] <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      `CHK(status, codes[8*i +: 8])
      @(posedge clk);
      pins[i] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK(status, 8'h00)
    run(CMD_FREE_MEM, 0, 32'h0, 1'b1, 8'h00);
    `CHK({rep[0], rep[1]}, USER_MEM_BYTES)
    run(CMD_CREATE_FIELD, 4, 32'h5504_0100, 1'b1, 8'h00);
    endOfTest();
  end
endmodule

bind encoder_param_cmd_decoder decoder_monitor u_mon (.clk(clk),
  .srst(srst), .rxByteValid(rxByteValid), .rxByte(rxByte),
  .rxFrameEnd(rxFrameEnd), .rxSumOk(rxSumOk), .overspeedPin(overspeedPin),
  .wdogResetPin(wdogResetPin), .analogFaultPin(analogFaultPin),
  .busFaultPin(busFaultPin), .tableBadPin(tableBadPin),
  .txByteValid(txByteValid), .txByte(txByte), .txLast(txLast),
  .status(status), .fieldWrite(fieldWrite), .fieldSel(fieldSel),
  .fieldAddr(fieldAddr), .fieldData(fieldData));
